// *** design/ethernet_interrupt_status_queue.sv ***
`timescale 1ns/1ns
`include "isq_defines.svh"
module ethernet_interrupt_status_queue (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic memRdStrobe,
    input wire logic memWrStrobe,
    input wire logic [11:0] memAddr,
    input wire logic [15:0] memWrData,
    input wire logic ioRdStrobe,
    input wire logic [3:0] ioAddr,
    output logic [15:0] rdData,
    output logic rdValid,
    input wire logic [9:0] rxEventPulse,
    input wire logic [9:0] rxEventEnable,
    input wire logic rxDmaMode,
    input wire logic [9:0] txEventPulse,
    input wire logic [9:0] txEventEnable,
    input wire logic [9:0] bufEventPulse,
    input wire logic [9:0] bufEventEnable,
    input wire logic rxMissPulse,
    input wire logic rxMissOverflowEnable,
    input wire logic txCollisionPulse,
    input wire logic txCollisionOverflowEnable,
    input wire logic irqEnable,
    input wire logic [9:0] lineStatus,
    input wire logic [9:0] selfStatus,
    input wire logic [9:0] busStatus,
    input wire logic [9:0] reflectorCount,
    output logic [15:0] testControl,
    output logic irqRequest
);
    logic [2:0] strobeSync;
    logic [2:0] strobeSeen_reg;
    logic [2:0] strobeSeen_next;
    logic memRdRise;
    logic memWrRise;
    logic ioRdRise;

    isq_pkg::content_type receive_event_reg;
    isq_pkg::content_type receive_event_next;
    isq_pkg::content_type transmit_event_reg;
    isq_pkg::content_type transmit_event_next;
    isq_pkg::content_type buffer_event_reg;
    isq_pkg::content_type buffer_event_next;
    isq_pkg::content_type missCount_reg;
    isq_pkg::content_type missCount_next;
    isq_pkg::content_type collisionCount_reg;
    isq_pkg::content_type collisionCount_next;
    logic rxPending_reg;
    logic rxPending_next;
    logic txPending_reg;
    logic txPending_next;
    logic bufPending_reg;
    logic bufPending_next;
    logic missPending_reg;
    logic missPending_next;
    logic collisionPending_reg;
    logic collisionPending_next;
    logic [15:0] testControl_reg;
    logic [15:0] testControl_next;
    logic [15:0] rdData_reg;
    logic [15:0] rdData_next;
    logic rdValid_reg;
    logic rdValid_next;
    logic irq_reg;
    logic irq_next;

    isq_pkg::source_type queueSource;
    logic [15:0] queueWord;
    logic queueRead;
    logic [9:0] rxEnabledMask;
    logic missOverflow;
    logic collisionOverflow;
    // Read side effects, one per source register
    logic rxClear;
    logic txClear;
    logic bufClear;
    logic missClear;
    logic collisionClear;
    logic anyPending;

    // Strobe pins pass two flops before any logic reads them
    sync_two_stage #(
        .WIDTH(3)
    ) i_sync_two_stage (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .asyncIn({ioRdStrobe, memWrStrobe, memRdStrobe}),
        .syncOut(strobeSync)
    );

    // A strobe acts once, on its first high sample
    assign memRdRise = strobeSync[0] & ~strobeSeen_reg[0];
    assign memWrRise = strobeSync[1] & ~strobeSeen_reg[1];
    assign ioRdRise = strobeSync[2] & ~strobeSeen_reg[2];

    // Both access modes reach the same queue word
    assign queueRead = (memRdRise && memAddr == `OFS_QUEUE_WORD) ||
        (ioRdRise && ioAddr == `IO_OFS_QUEUE_WORD);

    // Good-frame event never interrupts while frames go by DMA
    always_comb begin
        rxEnabledMask = rxEventEnable;
        if (rxDmaMode) begin
            rxEnabledMask[`GOOD_FRAME_BIT] = 1'b0;
        end
    end

    // Overflow is the step that carries into the top bit
    assign missOverflow = rxMissPulse && missCount_reg[`COUNT_TOP_BIT:0] == `COUNT_OVERFLOW_FROM;
    assign collisionOverflow = txCollisionPulse && collisionCount_reg == `COUNT_OVERFLOW_FROM;

    // One pending source at a time, fixed priority
    always_comb begin
        queueSource = isq_pkg::SRC_NONE;
        queueWord = `QUEUE_RESET;
        if (rxPending_reg) begin
            queueSource = isq_pkg::SRC_RECEIVE;
            queueWord = {receive_event_reg, `NUM_RECEIVE_EVENT};
        end else if (txPending_reg) begin
            queueSource = isq_pkg::SRC_TRANSMIT;
            queueWord = {transmit_event_reg, `NUM_TRANSMIT_EVENT};
        end else if (bufPending_reg) begin
            queueSource = isq_pkg::SRC_BUFFER;
            queueWord = {buffer_event_reg, `NUM_BUFFER_EVENT};
        end else if (missPending_reg) begin
            queueSource = isq_pkg::SRC_MISS;
            queueWord = {missCount_reg, `NUM_RECEIVE_MISS};
        end else if (collisionPending_reg) begin
            queueSource = isq_pkg::SRC_COLLISION;
            queueWord = {collisionCount_reg, `NUM_TRANSMIT_COLLISION};
        end
    end

    // Read data and the side effects of each read
    always_comb begin
        rxClear = 1'b0;
        txClear = 1'b0;
        bufClear = 1'b0;
        missClear = 1'b0;
        collisionClear = 1'b0;
        rdValid_next = memRdRise | ioRdRise;
        rdData_next = rdData_reg;

        if (queueRead) begin
            rdData_next = queueWord;
            unique case (queueSource)
                isq_pkg::SRC_NONE: begin
                end
                isq_pkg::SRC_RECEIVE: rxClear = 1'b1;
                isq_pkg::SRC_TRANSMIT: txClear = 1'b1;
                isq_pkg::SRC_BUFFER: bufClear = 1'b1;
                isq_pkg::SRC_MISS: missClear = 1'b1;
                isq_pkg::SRC_COLLISION: collisionClear = 1'b1;
            endcase
        end else if (memRdRise) begin
            unique case (memAddr)
                `OFS_TEST_CONTROL: rdData_next = testControl_reg;
                `OFS_RECEIVE_EVENT: begin
                    rdData_next = {receive_event_reg, `NUM_RECEIVE_EVENT};
                    rxClear = 1'b1;
                end
                `OFS_TRANSMIT_EVENT: begin
                    rdData_next = {transmit_event_reg, `NUM_TRANSMIT_EVENT};
                    txClear = 1'b1;
                end
                `OFS_BUFFER_EVENT: begin
                    rdData_next = {buffer_event_reg, `NUM_BUFFER_EVENT};
                    bufClear = 1'b1;
                end
                `OFS_RECEIVE_MISS: begin
                    rdData_next = {missCount_reg, `NUM_RECEIVE_MISS};
                    missClear = 1'b1;
                end
                `OFS_TRANSMIT_COLLISION: begin
                    rdData_next = {collisionCount_reg, `NUM_TRANSMIT_COLLISION};
                    collisionClear = 1'b1;
                end
                // Status views carry their own register numbers
                `OFS_LINE_STATUS: rdData_next = {lineStatus, `NUM_LINE_STATUS};
                `OFS_SELF_STATUS: rdData_next = {selfStatus, `NUM_SELF_STATUS};
                `OFS_BUS_STATUS: rdData_next = {busStatus, `NUM_BUS_STATUS};
                `OFS_REFLECTOR: rdData_next = {reflectorCount, `NUM_REFLECTOR};
                default: rdData_next = 16'h0000;
            endcase
        end else if (ioRdRise) begin
            rdData_next = 16'h0000;
        end
    end

    // Test control keeps its own number in the low field
    always_comb begin
        testControl_next = testControl_reg;
        if (memWrRise && memAddr == `OFS_TEST_CONTROL) begin
            testControl_next = {memWrData[15:6], `NUM_TEST_CONTROL};
        end
    end

    // Strobe history for edge detection
    always_comb begin
        strobeSeen_next = strobeSync;
    end

    // Set wins over a clear in the same cycle
    always_comb begin
        receive_event_next = (rxClear ? `CONTENT_ZERO : receive_event_reg) | rxEventPulse;
        transmit_event_next = (txClear ? `CONTENT_ZERO : transmit_event_reg) | txEventPulse;
        buffer_event_next = (bufClear ? `CONTENT_ZERO : buffer_event_reg) | bufEventPulse;
    end

    // Counters wrap within ten bits and restart from zero on a read
    always_comb begin
        missCount_next = (missClear ? `CONTENT_ZERO : missCount_reg) +
            (rxMissPulse ? `COUNT_ONE : `CONTENT_ZERO);
        collisionCount_next = (collisionClear ? `CONTENT_ZERO : collisionCount_reg) +
            (txCollisionPulse ? `COUNT_ONE : `CONTENT_ZERO);
    end

    // A source stays pending until the read that reports it
    always_comb begin
        rxPending_next = (rxPending_reg & ~rxClear) | (|(rxEventPulse & rxEnabledMask));
        txPending_next = (txPending_reg & ~txClear) | (|(txEventPulse & txEventEnable));
        bufPending_next = (bufPending_reg & ~bufClear) | (|(bufEventPulse & bufEventEnable));
        missPending_next = (missPending_reg & ~missClear) |
            (missOverflow & rxMissOverflowEnable);
        collisionPending_next = (collisionPending_reg & ~collisionClear) |
            (collisionOverflow & txCollisionOverflowEnable);
    end

    // Request follows the pending flags of the coming cycle
    always_comb begin
        anyPending = rxPending_next | txPending_next | bufPending_next | missPending_next |
            collisionPending_next;
        irq_next = irqEnable & anyPending;
    end

    // Strobe history
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            strobeSeen_reg <= 3'h0;
        end else begin
            strobeSeen_reg <= strobeSeen_next;
        end
    end

    // Bus side: read data, read valid and test control
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            testControl_reg <= `TEST_CONTROL_RESET;
            rdData_reg <= `QUEUE_RESET;
            rdValid_reg <= 1'b0;
        end else begin
            testControl_reg <= testControl_next;
            rdData_reg <= rdData_next;
            rdValid_reg <= rdValid_next;
        end
    end

    // Event registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            receive_event_reg <= `CONTENT_ZERO;
            transmit_event_reg <= `CONTENT_ZERO;
            buffer_event_reg <= `CONTENT_ZERO;
        end else begin
            receive_event_reg <= receive_event_next;
            transmit_event_reg <= transmit_event_next;
            buffer_event_reg <= buffer_event_next;
        end
    end

    // Overflow counters
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            missCount_reg <= `CONTENT_ZERO;
            collisionCount_reg <= `CONTENT_ZERO;
        end else begin
            missCount_reg <= missCount_next;
            collisionCount_reg <= collisionCount_next;
        end
    end

    // Pending flags
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rxPending_reg <= 1'b0;
            txPending_reg <= 1'b0;
            bufPending_reg <= 1'b0;
            missPending_reg <= 1'b0;
            collisionPending_reg <= 1'b0;
        end else begin
            rxPending_reg <= rxPending_next;
            txPending_reg <= txPending_next;
            bufPending_reg <= bufPending_next;
            missPending_reg <= missPending_next;
            collisionPending_reg <= collisionPending_next;
        end
    end

    // Interrupt request
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign rdData = rdData_reg;
    assign rdValid = rdValid_reg;
    assign testControl = testControl_reg;
    assign irqRequest = irq_reg;
endmodule

// *** design/isq_defines.svh ***
`ifndef ISQ_DEFINES_SVH
`define ISQ_DEFINES_SVH
// Overview of operation
// - An enabled event sets its bits in a source register, is offered in the queue word, and raises the interrupt request.
// - Five sources feed the queue, three of them event registers numbered 4, 8 and C.
// - The other two sources are overflow reports of the miss counter (10) and the collision counter (12).
// - The queue word is readable in memory mode and in I/O mode with the same content.
// - In memory mode the queue word sits at offset 120h of the register space.
// - In I/O mode the queue word sits at offset 0008h of the I/O window.
// - The low six bits of the queue word name the reported source register.
// - The upper ten bits of the queue word hold that source register's content.
// - After reset the queue word reads as zero.
// - The miss and collision counters are 10 bits wide and clear when read.
// - Reading the receive event register clears all of its bits.
// - The good-frame interrupt is raised only when enabled and never while receiving by DMA.

`define OFS_TEST_CONTROL 12'h118
`define OFS_QUEUE_WORD 12'h120
`define OFS_RECEIVE_EVENT 12'h124
`define OFS_TRANSMIT_EVENT 12'h128
`define OFS_BUFFER_EVENT 12'h12c
`define OFS_RECEIVE_MISS 12'h130
`define OFS_TRANSMIT_COLLISION 12'h132
`define OFS_LINE_STATUS 12'h134
`define OFS_SELF_STATUS 12'h136
`define OFS_BUS_STATUS 12'h138
`define OFS_REFLECTOR 12'h13c
`define IO_OFS_QUEUE_WORD 4'h8

`define NUM_RECEIVE_EVENT 6'h04
`define NUM_TRANSMIT_EVENT 6'h08
`define NUM_BUFFER_EVENT 6'h0c
`define NUM_RECEIVE_MISS 6'h10
`define NUM_TRANSMIT_COLLISION 6'h12
`define NUM_TEST_CONTROL 6'h19
`define NUM_LINE_STATUS 6'h14
`define NUM_SELF_STATUS 6'h16
`define NUM_BUS_STATUS 6'h18
`define NUM_REFLECTOR 6'h1c

`define CONTENT_LSB 6
`define CONTENT_WIDTH 10
`define GOOD_FRAME_BIT 2
`define COUNT_TOP_BIT 9
`define QUEUE_RESET 16'h0000
`define TEST_CONTROL_RESET 16'h0019
`define CONTENT_ZERO 10'h000
`define COUNT_ONE 10'h001
`define COUNT_OVERFLOW_FROM 10'h1ff
`endif

// *** design/isq_pkg.sv ***
package isq_pkg;
    typedef enum logic [2:0] {
        SRC_NONE = 3'b000,
        SRC_RECEIVE = 3'b001,
        SRC_TRANSMIT = 3'b010,
        SRC_BUFFER = 3'b011,
        SRC_MISS = 3'b100,
        SRC_COLLISION = 3'b101
    } source_type;
    typedef logic [9:0] content_type;
endpackage

// *** design/sync_two_stage.sv ***
`timescale 1ns/1ns
module sync_two_stage #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] firstStage_reg;
    logic [WIDTH-1:0] secondStage_reg;

    // First stage is read only by the second
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            firstStage_reg <= '0;
            secondStage_reg <= '0;
        end else begin
            firstStage_reg <= asyncIn;
            secondStage_reg <= firstStage_reg;
        end
    end

    assign syncOut = secondStage_reg;
endmodule

// *** dv/isa_host_model.sv ***
`timescale 1ns/1ns
module isa_host_model (
    input wire logic clk_sys,
    input wire logic [15:0] rdData,
    input wire logic rdValid,
    output logic memRdStrobe,
    output logic memWrStrobe,
    output logic [11:0] memAddr,
    output logic [15:0] memWrData,
    output logic ioRdStrobe,
    output logic [3:0] ioAddr,
    output logic hung
);
    initial begin
        {memRdStrobe, memWrStrobe, ioRdStrobe, hung} = 4'h0;
        {memAddr, memWrData, ioAddr} = 32'h0;
    end
    task automatic rd(input logic io, input logic [11:0] a, output logic [15:0] d);
        int n;
        @(posedge clk_sys);
        #1;
        if (io) begin
            ioAddr = a[3:0];
            ioRdStrobe = 1'b1;
        end else begin
            memAddr = a;
            memRdStrobe = 1'b1;
        end
        n = 0;
        @(posedge clk_sys);
        while (rdValid !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        hung = hung | (n >= 20);
        d = rdData;
        #1;
        {memRdStrobe, ioRdStrobe} = 2'h0;
        memAddr = ~memAddr;
        ioAddr = ~ioAddr;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        #1;
        memAddr = a;
        memWrData = v;
        memWrStrobe = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        memWrStrobe = 1'b0;
        memAddr = ~memAddr;
        memWrData = ~memWrData;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
endmodule

// *** dv/isq_monitor.sv ***
`timescale 1ns/1ns
module isq_monitor (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic memRdStrobe,
    input wire logic [11:0] memAddr,
    input wire logic ioRdStrobe,
    input wire logic [3:0] ioAddr,
    input wire logic [9:0] rxEventPulse,
    input wire logic [9:0] rxEventEnable,
    input wire logic rxDmaMode,
    input wire logic [9:0] txEventPulse,
    input wire logic [9:0] bufEventPulse,
    input wire logic rxMissPulse,
    input wire logic txCollisionPulse,
    input wire logic irqEnable,
    input logic [15:0] rdData,
    input logic rdValid,
    input logic irqRequest
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    property p_rst; $rose(rst_b) |-> rdData == 16'h0000 && !irqRequest; endproperty
    a_rst: assert property (p_rst) else $error("queue word not zero after reset");
    property p_pulse; rdValid |=> !rdValid; endproperty
    a_pulse: assert property (p_pulse) else $error("read valid longer than one cycle");
    property p_mem; $rose(memRdStrobe) |-> ##[2:4] rdValid; endproperty
    a_mem: assert property (p_mem) else $error("memory read not answered");
    property p_io; $rose(ioRdStrobe) && ioAddr != 4'h8 |-> ##[2:4] rdValid && rdData == 16'h0000;
    endproperty
    a_io: assert property (p_io) else $error("unmapped io read not zero");
    property p_num; memRdStrobe && memAddr == 12'h120 && rdValid |->
        rdData[5:0] inside {6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h12} &&
        (rdData[5:0] != 6'h00 || rdData == 16'h0000); endproperty
    a_num: assert property (p_num) else $error("bad queue register number");
    property p_off; !irqEnable |=> !irqRequest; endproperty
    a_off: assert property (p_off) else $error("request while disabled");
    property p_on; rxEventPulse[2] && rxEventEnable[2] && !rxDmaMode && irqEnable |=> irqRequest;
    endproperty
    a_on: assert property (p_on) else $error("enabled event gave no request");
    property p_dma; rxDmaMode && rxEventPulse == 10'h004 && !irqRequest &&
        !(|{txEventPulse, bufEventPulse, rxMissPulse, txCollisionPulse}) |=> !irqRequest;
    endproperty
    a_dma: assert property (p_dma) else $error("good frame request in dma mode");
endmodule
bind ethernet_interrupt_status_queue isq_monitor i_isq_monitor (.clk_sys, .rst_b, .memRdStrobe,
    .memAddr, .ioRdStrobe, .ioAddr, .rxEventPulse, .rxEventEnable, .rxDmaMode, .txEventPulse,
    .bufEventPulse, .rxMissPulse, .txCollisionPulse, .irqEnable, .rdData, .rdValid, .irqRequest);

// *** dv/test_ethernet_interrupt_status_queue.sv ***
`timescale 1ns/1ns
module test_ethernet_interrupt_status_queue;
    logic clk_sys, rst_b, memRdStrobe, memWrStrobe, ioRdStrobe, rdValid, hung, irqRequest;
    logic rxDmaMode, rxMissPulse, txCollisionPulse, ovE, irqEnable;
    logic [11:0] memAddr;
    logic [15:0] memWrData, rdData, testControl, d;
    logic [3:0] ioAddr;
    logic [9:0] rxEventPulse, rxEventEnable, txEventPulse, txEventEnable, st;
    logic [9:0] bufEventPulse, bufEventEnable;
    int n_fail, tests_run;
    ethernet_interrupt_status_queue i_ethernet_interrupt_status_queue (.clk_sys, .rst_b,
        .memRdStrobe, .memWrStrobe, .memAddr, .memWrData, .ioRdStrobe, .ioAddr, .rdData,
        .rdValid, .rxEventPulse, .rxEventEnable, .rxDmaMode, .txEventPulse, .txEventEnable,
        .bufEventPulse, .bufEventEnable, .rxMissPulse, .rxMissOverflowEnable(ovE),
        .txCollisionPulse, .txCollisionOverflowEnable(ovE), .irqEnable, .lineStatus(st),
        .selfStatus(st), .busStatus(st), .reflectorCount(st), .testControl, .irqRequest);
    isa_host_model i_isa_host_model (.clk_sys, .rdData, .rdValid, .memRdStrobe, .memWrStrobe,
        .memAddr, .memWrData, .ioRdStrobe, .ioAddr, .hung);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic io, input logic [11:0] a, input logic [15:0] exp);
        i_isa_host_model.rd(io, a, d);
        check("read", d, exp);
        if (hung) close_out();
    endtask
    task automatic irq(input logic exp);
        check("irq", {15'h0000, irqRequest}, {15'h0000, exp});
    endtask
    task automatic ev(input logic [9:0] r, t, b, input logic m, c);
        @(posedge clk_sys);
        #1;
        {rxEventPulse, txEventPulse, bufEventPulse, rxMissPulse, txCollisionPulse} = {r, t, b, m, c};
        @(posedge clk_sys);
        #1;
        {rxEventPulse, txEventPulse, bufEventPulse, rxMissPulse, txCollisionPulse} = 32'h0;
    endtask
    task automatic close_out;
        if (hung) n_fail++;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        {rst_b, rxDmaMode, rxMissPulse, txCollisionPulse} = 4'h0;
        {rxEventPulse, txEventPulse, bufEventPulse} = 30'h0;
        {rxEventEnable, txEventEnable, bufEventEnable} = {10'h004, 10'h008, 10'h020};
        {ovE, irqEnable, st} = {2'b11, 10'h2a5};
        n_fail = 0;
        tests_run = 0;
        repeat (10) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        check("testControl", testControl, 16'h0019);
        rd(0, 12'h120, 16'h0000);
        i_isa_host_model.wr(12'h118, 16'habcd);
        check("testControl", testControl, 16'habd9);
        rd(0, 12'h134, {st, 6'h14});
        ev(10'h004, 10'h000, 10'h000, 0, 0);
        irq(1);
        rd(0, 12'h120, {10'h004, 6'h04});
        irq(0);
        rd(0, 12'h120, 16'h0000);
        rxDmaMode = 1'b1;
        ev(10'h004, 10'h000, 10'h000, 0, 0);
        irq(0);
        rd(0, 12'h124, {10'h004, 6'h04});
        rd(0, 12'h124, {10'h000, 6'h04});
        rxDmaMode = 1'b0;
        irqEnable = 1'b0;
        ev(10'h004, 10'h000, 10'h000, 0, 0);
        irq(0);
        irqEnable = 1'b1;
        ev(10'h040, 10'h008, 10'h020, 0, 0);
        rd(1, 12'h008, {10'h044, 6'h04});
        rd(0, 12'h120, {10'h008, 6'h08});
        rd(1, 12'h008, {10'h020, 6'h0c});
        rd(1, 12'h003, 16'h0000);
        rd(1, 12'h008, 16'h0000);
        ev(10'h000, 10'h100, 10'h000, 0, 0);
        irq(0);
        rd(0, 12'h128, {10'h100, 6'h08});
        ev(10'h000, 10'h000, 10'h010, 0, 0);
        irq(0);
        rd(0, 12'h12c, {10'h010, 6'h0c});
        rd(0, 12'h136, {st, 6'h16});
        rd(0, 12'h138, {st, 6'h18});
        rd(0, 12'h13c, {st, 6'h1c});
        rd(0, 12'h122, 16'h0000);
        repeat (511) ev(10'h000, 10'h000, 10'h000, 1, 1);
        irq(0);
        ev(10'h000, 10'h000, 10'h000, 1, 1);
        irq(1);
        rd(0, 12'h120, {10'h200, 6'h10});
        rd(0, 12'h120, {10'h200, 6'h12});
        rd(0, 12'h130, {10'h000, 6'h10});
        repeat (3) ev(10'h000, 10'h000, 10'h000, 0, 1);
        rd(0, 12'h132, {10'h003, 6'h12});
        rd(0, 12'h132, {10'h000, 6'h12});
        close_out();
    end
endmodule
